// ### dv/irq_accept_seq_sva.sv
// checker for the interrupt acceptance sequencer ports
`timescale 1ns/1ps
`default_nettype none

module irq_accept_seq_chk #(
   parameter int unsigned N  = 8,              // number of sources
   parameter int unsigned IW = 3               // source index width
) (
   input  wire logic                    CLK_I,        // core clock
   input  wire logic                    SYS_RST_I,    // sync reset
   input  wire logic [N-1:0]            SRC_EVENT_I,  // source events
   input  wire logic [N-1:0]            SRC_EN_I,     // source enables
   input  wire logic [N-1:0]            SRC_CLR_I,    // software clears
   input  wire logic [N-1:0]            IRQ_PEND_O,   // pending flags
   input  wire logic                    SEL_VLD_O,    // presented
   input  wire logic [IW-1:0]           SEL_IDX_O,    // presented source
   input  wire logic                    INSN_DONE_I,  // boundary strobe
   input  wire logic                    RTE_I,        // return
   input  wire logic [15:0]             NEXT_PC_I,    // next pc
   input  wire logic [7:0]              CCR_I,        // flags
   input  wire logic [15:0]             SP_I,         // stack pointer
   input  wire irq_seq_pkg::mem_req_t   MEM_O,        // memory request
   input  wire irq_seq_pkg::core_load_t LOAD_O,       // core loads
   input  wire logic                    ACCEPT_O,     // accept pulse
   input  wire logic [IW-1:0]           ACCEPT_IDX_O, // accepted source
   input  wire logic                    BUSY_O        // busy
);
   // ==========================================================
   // helper masks
   logic [N-1:0] elig;                         // sources that may be shown
   logic [N-1:0] evok;                         // events that must pend
   logic [N-1:0] low;                          // sources ranked above pick
   assign elig = CCR_I[7] ? N'(3) : {N{1'b1}};
   assign evok = SRC_EVENT_I & (SRC_EN_I | N'(3));
   assign low  = (N'(1) << SEL_IDX_O) - N'(1);

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);

   // ==========================================================
   // assertions
   a_event_pends: assert property (1'b1 |=> ((IRQ_PEND_O & $past(evok)) == $past(evok)) || ACCEPT_O)
      else $error("enabled event did not pend");
   a_no_stray_pend: assert property ((IRQ_PEND_O & ~$past(IRQ_PEND_O) & ~$past(evok)) == '0)
      else $error("pending flag set without an enabled event");
   a_pend_holds: assert property (((($past(IRQ_PEND_O) & ~IRQ_PEND_O & ~$past(SRC_CLR_I)) == '0)) || ACCEPT_O)
      else $error("pending request lost");
   a_pick_highest: assert property (SEL_VLD_O |-> IRQ_PEND_O[SEL_IDX_O] && ((IRQ_PEND_O & elig & low) == '0))
      else $error("presented request is not the highest eligible");
   a_eligible_shown: assert property (|(IRQ_PEND_O & elig) |-> SEL_VLD_O)
      else $error("eligible request not presented");
   a_mask_gates: assert property (ACCEPT_O && ACCEPT_IDX_O >= IW'(2) |-> !$past(CCR_I[7]))
      else $error("maskable request accepted while masked");
   a_boundary_only: assert property (ACCEPT_O |-> $past(INSN_DONE_I && !RTE_I && !BUSY_O && SEL_VLD_O))
      else $error("accept outside an idle instruction boundary");
   a_first_push: assert property (ACCEPT_O |-> BUSY_O && MEM_O.req && MEM_O.we
         && MEM_O.addr == $past(SP_I) - 16'h0002 && MEM_O.wdata == $past(NEXT_PC_I))
      else $error("first push not return address at sp minus two");
   a_mask_then_vec: assert property (LOAD_O.ccr_ld && BUSY_O && !LOAD_O.pc_ld
         |-> LOAD_O.condition_code_register[7] ##1 (LOAD_O.pc_ld && !LOAD_O.ccr_ld))
      else $error("mask flag not set before vector jump");
   a_vector_load: assert property (LOAD_O.pc_ld && BUSY_O
         |-> LOAD_O.pc == 16'h0020 + (16'(ACCEPT_IDX_O) << 1))
      else $error("vector address wrong");
   a_return_pop: assert property ($past(!SYS_RST_I && INSN_DONE_I && RTE_I && !BUSY_O)
         |-> MEM_O.req && !MEM_O.we && MEM_O.addr == $past(SP_I))
      else $error("return does not read flags at sp");
endmodule // irq_accept_seq_chk

bind irq_accept_seq irq_accept_seq_chk #(.N(N), .IW(IW)) irq_accept_seq_chk_inst (
   .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SRC_EVENT_I(SRC_EVENT_I), .SRC_EN_I(SRC_EN_I),
   .SRC_CLR_I(SRC_CLR_I), .IRQ_PEND_O(IRQ_PEND_O), .SEL_VLD_O(SEL_VLD_O), .SEL_IDX_O(SEL_IDX_O),
   .INSN_DONE_I(INSN_DONE_I), .RTE_I(RTE_I), .NEXT_PC_I(NEXT_PC_I), .CCR_I(CCR_I), .SP_I(SP_I),
   .MEM_O(MEM_O), .LOAD_O(LOAD_O), .ACCEPT_O(ACCEPT_O), .ACCEPT_IDX_O(ACCEPT_IDX_O), .BUSY_O(BUSY_O));
`default_nettype wire

// ### dv/irq_accept_seq_tb_top.sv
// self-checking bench for the interrupt acceptance sequencer
`timescale 1ns/1ps
`default_nettype none

module irq_accept_seq_tb_top;
   // ==========================================================
   // stimulus and observed signals
   logic clk = 1'b0, rst = 1'b1, done = 1'b0, rte = 1'b0, ack, acc_seen;
   logic [7:0]  ev = 8'h00, en = 8'hBF, clr = 8'h00, condition_code_register = 8'h80, pend;
   logic [15:0] npc = 16'h0000, sp = 16'h0400, rdata, last_pc, last_ccr, last_sp;
   logic        sel_vld, accept, busy;
   logic [2:0]  sel_idx, acc_idx;
   irq_seq_pkg::mem_req_t   mem;
   irq_seq_pkg::core_load_t load;
   int fail_count = 0, samples_checked = 0;

   always #4 clk = ~clk;                       // 125 MHz

   irq_accept_seq irq_accept_seq_inst (.CLK_I(clk), .SYS_RST_I(rst), .SRC_EVENT_I(ev), .SRC_EN_I(en),
      .SRC_CLR_I(clr), .IRQ_PEND_O(pend), .SEL_VLD_O(sel_vld), .SEL_IDX_O(sel_idx), .INSN_DONE_I(done),
      .RTE_I(rte), .NEXT_PC_I(npc), .CCR_I(condition_code_register), .SP_I(sp), .MEM_O(mem), .MEM_ACK_I(ack),
      .MEM_RDATA_I(rdata), .LOAD_O(load), .ACCEPT_O(accept), .ACCEPT_IDX_O(acc_idx), .BUSY_O(busy));
   irq_mem_model irq_mem_model_inst (.clk_i(clk), .rst_i(rst), .mem_i(mem), .ack_o(ack), .rdata_o(rdata));

   // captures core loads and accepts for later comparison
   always @(posedge clk) begin
      if (load.pc_ld) last_pc <= load.pc;
      if (load.ccr_ld) last_ccr <= {8'h00, load.condition_code_register};
      if (load.sp_ld) last_sp <= load.sp;
      acc_seen <= rst ? 1'b0 : (acc_seen | accept);
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic pulse_ev(input logic [7:0] m);
      @(negedge clk) ev = m;
      @(negedge clk) ev = 8'h00;
   endtask
   task automatic boundary(input logic r);
      @(negedge clk) begin done = 1'b1; rte = r; end
      @(negedge clk) begin done = 1'b0; rte = 1'b0; end
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk);
      if (busy !== 1'b0) check("busy timeout", 16'h0000, 16'(busy));
      @(negedge clk);
   endtask
   // entry then return, stack contents and loads compared
   task automatic entry_return(input logic [2:0] idx, input logic [15:0] pc, input logic [7:0] c,
                               input logic [15:0] s);
      npc = pc; condition_code_register = c; sp = s;
      boundary(1'b0);
      check("accepted source", 16'(idx), 16'(acc_idx));
      wait_idle();
      check("stacked pc", pc, irq_mem_model_inst.mem[16'(s - 16'h0002) >> 1]);
      check("stacked flags", {8'h00, c}, irq_mem_model_inst.mem[16'(s - 16'h0004) >> 1]);
      check("mask set", {8'h00, c | 8'h80}, last_ccr);
      check("vector", 16'h0020 + 16'(idx) * 16'h0002, last_pc);
      check("stacked sp", 16'(s - 16'h0004), last_sp);
      sp = s - 16'h0004; condition_code_register = c | 8'h80;
      boundary(1'b1);
      wait_idle();
      check("restored pc", pc, last_pc);
      check("restored flags", {8'h00, c}, last_ccr);
      check("restored sp", s, last_sp);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_masked();
      pulse_ev(8'h48);                         // source 6 disabled
      check("pend masked", 16'h0008, 16'(pend));
      check("masked not shown", 16'h0000, 16'(sel_vld));
      repeat (3) @(negedge clk);
      check("no accept off boundary", 16'h0000, 16'(acc_seen));
      boundary(1'b0);
      repeat (2) @(negedge clk);
      check("masked not accepted", 16'h0000, 16'(acc_seen));
      check("masked still pending", 16'h0008, 16'(pend));
      pulse_ev(8'h01);
      entry_return(3'h0, 16'h1234, 8'h80, 16'h0002);
      check("pend after nmi", 16'h0008, 16'(pend));
   endtask
   task automatic t_priority();
      condition_code_register = 8'h15;
      pulse_ev(8'h20);
      check("pend both", 16'h0028, 16'(pend));
      check("pick highest", 16'h0003, 16'(sel_idx));
      entry_return(3'h3, 16'hABCE, 8'h15, 16'h0400);
      check("lower still pending", 16'h0020, 16'(pend));
      @(negedge clk) clr = 8'h20;
      @(negedge clk) clr = 8'h00;
      check("cleared", 16'h0000, 16'(pend));
   endtask

   task automatic stop_test();
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge clk);
      check("pend reset", 16'h0000, 16'(pend));
      check("busy reset", 16'h0000, 16'({busy, mem.req, accept}));
      rst = 1'b0;
      t_masked();
      t_priority();
      stop_test();
   end

   // watchdog well beyond the fewer than one hundred cycles the tests use
   initial begin
      #(8 * 5000);
      fail_count++;
      stop_test();
   end
endmodule // irq_accept_seq_tb_top
`default_nettype wire

// ### dv/irq_mem_model.sv
// stack memory model answering the sequencer's word accesses
`timescale 1ns/1ps
`default_nettype none

module irq_mem_model (
   input  wire logic                  clk_i,   // core clock
   input  wire logic                  rst_i,   // sync reset, high
   input  wire irq_seq_pkg::mem_req_t mem_i,   // request from sequencer
   output logic                       ack_o,   // one-cycle done pulse
   output logic [15:0]                rdata_o  // read data with ack
);
   // ==========================================================
   // storage and wait-state control
   logic [15:0] mem [0:32767];                 // word array
   logic [1:0]  cnt_q;                         // wait cycles seen
   logic        slow_q;                        // alternate fast and slow

   // answers after 0 or 3 waits in turn; idle data toggles so stale reads show
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o   <= 1'b0;
         cnt_q   <= 2'h0;
         slow_q  <= 1'b0;
         rdata_o <= 16'hA5A5;
      end else begin
         ack_o   <= 1'b0;
         rdata_o <= ~rdata_o;
         if (mem_i.req && !ack_o) begin
            if (cnt_q == {slow_q, slow_q}) begin
               ack_o  <= 1'b1;
               cnt_q  <= 2'h0;
               slow_q <= ~slow_q;
               if (mem_i.we) mem[mem_i.addr[15:1]] <= mem_i.wdata;
               else rdata_o <= mem[mem_i.addr[15:1]];
            end else begin
               cnt_q <= cnt_q + 2'h1;
            end
         end
      end
   end
endmodule // irq_mem_model
`default_nettype wire

// ### verilog/irq_accept_seq.sv
// interrupt acceptance and exception entry/return sequencer
//
// Notes on behaviour
// - enabled or non-maskable event raises a request
// - only highest-priority request presented, rest wait
// - nmi and address break ignore mask
// - others taken only with mask clear
// - acceptance only at an instruction boundary
// - push return address and flags first
// - then set mask flag to one
// - return restores all flags from stack
// - load vector address into program counter
// - generated addresses keep low 16 bits
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_regs.svh"

module irq_accept_seq #(
   parameter int unsigned N  = 8,                 // number of sources
   parameter int unsigned IW = 3,                 // source index width
   parameter logic [N*8-1:0] PRIO_LIST = 64'h0706050403020100,
   parameter logic [N*`IRQ_FULL_W-1:0] VEC_TABLE = {
      24'h00002E, 24'h00002C, 24'h00002A, 24'h000028,
      24'h000026, 24'h000024, 24'h000022, 24'h000020}
) (
   input  wire logic                   CLK_I,        // core clock
   input  wire logic                   SYS_RST_I,    // sync reset, high
   input  wire logic [N-1:0]           SRC_EVENT_I,  // source events
   input  wire logic [N-1:0]           SRC_EN_I,     // source enables
   input  wire logic [N-1:0]           SRC_CLR_I,    // software clears
   output logic [N-1:0]                IRQ_PEND_O,   // pending requests
   output logic                        SEL_VLD_O,    // request presented
   output logic [IW-1:0]               SEL_IDX_O,    // presented source
   input  wire logic                   INSN_DONE_I,  // boundary strobe
   input  wire logic                   RTE_I,        // return at boundary
   input  wire logic [`IRQ_ADDR_W-1:0] NEXT_PC_I,    // next instruction
   input  wire logic [`IRQ_CCR_W-1:0]  CCR_I,        // current flags
   input  wire logic [`IRQ_ADDR_W-1:0] SP_I,         // stack pointer
   output irq_seq_pkg::mem_req_t       MEM_O,        // memory request
   input  wire logic                   MEM_ACK_I,    // memory done
   input  wire logic [`IRQ_DATA_W-1:0] MEM_RDATA_I,  // read data
   output irq_seq_pkg::core_load_t     LOAD_O,       // core loads
   output logic                        ACCEPT_O,     // accept pulse
   output logic [IW-1:0]               ACCEPT_IDX_O, // accepted source
   output logic                        BUSY_O        // core must hold
);

   // =====================================================
   // state
   irq_seq_pkg::seq_state_t      state_q, state_d;   // sequencer state
   logic [N-1:0]                 pend_q, pend_d;     // pending flags
   logic [IW-1:0]                idx_q, idx_d;       // accepted source
   logic [`IRQ_FULL_W-1:0]       vec_q, vec_d;       // handler vector
   logic [`IRQ_FULL_W-1:0]       sp_q, sp_d;         // working sp
   logic [`IRQ_ADDR_W-1:0]       pc_q, pc_d;         // return address
   logic [`IRQ_CCR_W-1:0]        ccr_q, ccr_d;       // saved flags
   irq_seq_pkg::mem_req_t        mem_q, mem_d;       // bus request
   irq_seq_pkg::core_load_t      ld_q, ld_d;         // core loads
   logic                         acc_q, acc_d;       // accept pulse

   // =====================================================
   // picker outputs
   logic                         pick_vld;           // candidate exists
   logic [IW-1:0]                pick_idx;           // candidate source
   logic [`IRQ_FULL_W-1:0]       pick_vec;           // candidate vector
   logic                         take;               // accept this cycle

   // =====================================================
   // priority selection against the live mask flag
   irq_rank_pick #(
      .N         (N),
      .IW        (IW),
      .PRIO_LIST (PRIO_LIST),
      .VEC_TABLE (VEC_TABLE)
   ) u_pick (
      .pend_i (pend_q),
      .mask_i (CCR_I[`IRQ_CCR_IBIT]),
      .vld_o  (pick_vld),
      .idx_o  (pick_idx),
      .vec_o  (pick_vec)
   );

   // accept at a boundary, return takes precedence
   assign take = (state_q == irq_seq_pkg::ST_IDLE) && INSN_DONE_I &&
                 !RTE_I && pick_vld;

   // =====================================================
   // pending flags, one per source
   generate
      for (genvar k = 0; k < N; k++) begin : g_pend
         logic set_k; // new event qualified
         logic clr_k; // accepted or cleared
         // event counts when enabled or non-maskable
         assign set_k = SRC_EVENT_I[k] &&
                        (SRC_EN_I[k] || irq_seq_pkg::nonmask(k));
         assign clr_k = SRC_CLR_I[k] ||
                        (take && pick_idx == IW'(k));
         // set wins over clear; a flag is one bit, never doubled
         always_comb begin
            pend_d[k] = set_k || (pend_q[k] && !clr_k);
         end
      end
   endgenerate

   // =====================================================
   // sequencer next-state
   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      vec_d   = vec_q;
      sp_d    = sp_q;
      pc_d    = pc_q;
      ccr_d   = ccr_q;
      mem_d   = mem_q;
      ld_d    = ld_q;
      ld_d.pc_ld  = 1'b0;
      ld_d.ccr_ld = 1'b0;
      ld_d.sp_ld  = 1'b0;
      acc_d   = 1'b0;
      unique case (state_q)
         // wait for the instruction in progress to end
         irq_seq_pkg::ST_IDLE: begin
            if (INSN_DONE_I && RTE_I) begin
               // return: pop flags word first
               sp_d       = {8'h00, SP_I};
               mem_d.req  = 1'b1;
               mem_d.we   = 1'b0;
               mem_d.addr = SP_I;
               state_d    = irq_seq_pkg::ST_RET_CCR;
            end else if (take) begin
               // latch request and context, push pc
               idx_d       = pick_idx;
               vec_d       = pick_vec;
               pc_d        = NEXT_PC_I;
               ccr_d       = CCR_I;
               acc_d       = 1'b1;
               sp_d        = {8'h00, SP_I} - `IRQ_STK_STEP;
               mem_d.req   = 1'b1;
               mem_d.we    = 1'b1;
               mem_d.addr  = sp_d[`IRQ_ADDR_W-1:0];
               mem_d.wdata = NEXT_PC_I;
               state_d     = irq_seq_pkg::ST_PUSH_PC;
            end
         end
         // pc word written, push flags word
         irq_seq_pkg::ST_PUSH_PC: begin
            if (MEM_ACK_I) begin
               sp_d        = sp_q - `IRQ_STK_STEP;
               mem_d.addr  = sp_d[`IRQ_ADDR_W-1:0];
               mem_d.wdata = {8'h00, ccr_q};
               state_d     = irq_seq_pkg::ST_PUSH_CCR;
            end
         end
         // flags written, raise mask and move sp
         irq_seq_pkg::ST_PUSH_CCR: begin
            if (MEM_ACK_I) begin
               mem_d.req   = 1'b0;
               mem_d.we    = 1'b0;
               ld_d.ccr_ld = 1'b1;
               ld_d.condition_code_register    = ccr_q;
               ld_d.condition_code_register[`IRQ_CCR_IBIT] = 1'b1;
               ld_d.sp_ld  = 1'b1;
               ld_d.sp     = sp_q[`IRQ_ADDR_W-1:0];
               state_d     = irq_seq_pkg::ST_SET_MASK;
            end
         end
         // mask now set, jump to handler
         irq_seq_pkg::ST_SET_MASK: begin
            ld_d.pc_ld = 1'b1;
            ld_d.pc    = vec_q[`IRQ_ADDR_W-1:0];
            state_d    = irq_seq_pkg::ST_LOAD_VEC;
         end
         // handler start loaded, core resumes
         irq_seq_pkg::ST_LOAD_VEC: begin
            state_d = irq_seq_pkg::ST_IDLE;
         end
         // flags word read, fetch return address
         irq_seq_pkg::ST_RET_CCR: begin
            if (MEM_ACK_I) begin
               ccr_d      = MEM_RDATA_I[`IRQ_CCR_W-1:0];
               sp_d       = sp_q + `IRQ_STK_STEP;
               mem_d.addr = sp_d[`IRQ_ADDR_W-1:0];
               state_d    = irq_seq_pkg::ST_RET_PC;
            end
         end
         // return address read, restore everything
         irq_seq_pkg::ST_RET_PC: begin
            if (MEM_ACK_I) begin
               sp_d        = sp_q + `IRQ_STK_STEP;
               mem_d.req   = 1'b0;
               ld_d.pc_ld  = 1'b1;
               ld_d.pc     = MEM_RDATA_I;
               ld_d.ccr_ld = 1'b1;
               ld_d.condition_code_register    = ccr_q;
               ld_d.sp_ld  = 1'b1;
               ld_d.sp     = sp_d[`IRQ_ADDR_W-1:0];
               state_d     = irq_seq_pkg::ST_IDLE;
            end
         end
         // unused code: recover quietly
         default: begin
            state_d   = irq_seq_pkg::ST_IDLE;
            mem_d.req = 1'b0;
         end
      endcase
   end

   // =====================================================
   // registers
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state_q     <= irq_seq_pkg::ST_IDLE;
         pend_q      <= '0;
         idx_q       <= '0;
         vec_q       <= `IRQ_RST_FULL;
         sp_q        <= `IRQ_RST_FULL;
         pc_q        <= `IRQ_RST_ADDR;
         ccr_q       <= `IRQ_RST_CCR;
         mem_q.req   <= 1'b0;
         mem_q.we    <= 1'b0;
         mem_q.addr  <= `IRQ_RST_ADDR;
         mem_q.wdata <= `IRQ_RST_DATA;
         ld_q.pc_ld  <= 1'b0;
         ld_q.pc     <= `IRQ_RST_ADDR;
         ld_q.ccr_ld <= 1'b0;
         ld_q.condition_code_register    <= `IRQ_RST_CCR;
         ld_q.sp_ld  <= 1'b0;
         ld_q.sp     <= `IRQ_RST_ADDR;
         acc_q       <= 1'b0;
      end else begin
         state_q <= state_d;
         pend_q  <= pend_d;
         idx_q   <= idx_d;
         vec_q   <= vec_d;
         sp_q    <= sp_d;
         pc_q    <= pc_d;
         ccr_q   <= ccr_d;
         mem_q   <= mem_d;
         ld_q    <= ld_d;
         acc_q   <= acc_d;
      end
   end

   // =====================================================
   // outputs
   assign IRQ_PEND_O   = pend_q;
   assign SEL_VLD_O    = pick_vld;
   assign SEL_IDX_O    = pick_idx;
   assign MEM_O        = mem_q;
   assign LOAD_O       = ld_q;
   assign ACCEPT_O     = acc_q;
   assign ACCEPT_IDX_O = idx_q;
   // hold the core from boundary until the sequence ends
   assign BUSY_O = (state_q != irq_seq_pkg::ST_IDLE);

endmodule // irq_accept_seq

`default_nettype wire

// ### verilog/irq_rank_pick.sv
// fixed-priority pick of one pending interrupt source
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_regs.svh"

module irq_rank_pick #(
   parameter int unsigned N  = 8,                 // number of sources
   parameter int unsigned IW = 3,                 // source index width
   parameter logic [N*8-1:0] PRIO_LIST = 64'h0706050403020100,
   parameter logic [N*`IRQ_FULL_W-1:0] VEC_TABLE = {
      24'h00002E, 24'h00002C, 24'h00002A, 24'h000028,
      24'h000026, 24'h000024, 24'h000022, 24'h000020}
) (
   input  wire logic [N-1:0]           pend_i, // pending sources
   input  wire logic                   mask_i, // mask flag
   output logic                        vld_o,  // a source chosen
   output logic [IW-1:0]               idx_o,  // chosen source
   output logic [`IRQ_FULL_W-1:0]      vec_o   // its vector
);

   // =====================================================
   // rank walk: rank 0 is highest, visited last so it wins
   always_comb begin
      int unsigned s;
      s     = 0;
      vld_o = 1'b0;
      idx_o = '0;
      vec_o = `IRQ_RST_FULL;
      for (int r = N - 1; r >= 0; r--) begin
         s = int'(PRIO_LIST[r*8 +: 8]);
         // maskable ones only while mask is clear
         if (s < N && pend_i[s] &&
             (!mask_i || irq_seq_pkg::nonmask(s))) begin
            vld_o = 1'b1;
            idx_o = IW'(s);
            vec_o = VEC_TABLE[s*`IRQ_FULL_W +: `IRQ_FULL_W];
         end
      end
   end

endmodule // irq_rank_pick

`default_nettype wire

// ### verilog/irq_seq_pkg.sv
// types shared by the interrupt acceptance sequencer
`include "irq_seq_regs.svh"

package irq_seq_pkg;

   // =====================================================
   // sequencer states, gray along the entry path
   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,   // waiting for a boundary
      ST_PUSH_PC  = 3'h1,   // stacking return address
      ST_PUSH_CCR = 3'h3,   // stacking flags
      ST_SET_MASK = 3'h2,   // raising mask flag
      ST_LOAD_VEC = 3'h6,   // jumping to handler
      ST_RET_CCR  = 3'h7,   // popping flags
      ST_RET_PC   = 3'h5    // popping return address
   } seq_state_t;

   // =====================================================
   // memory request toward the core bus
   typedef struct packed {
      logic                   req;    // access pending
      logic                   we;     // 1 write, 0 read
      logic [`IRQ_ADDR_W-1:0] addr;   // effective address
      logic [`IRQ_DATA_W-1:0] wdata;  // write data
   } mem_req_t;

   // =====================================================
   // register loads into the core
   typedef struct packed {
      logic                   pc_ld;  // load program counter
      logic [`IRQ_ADDR_W-1:0] pc;     // new program counter
      logic                   ccr_ld; // load flags
      logic [`IRQ_CCR_W-1:0]  condition_code_register;    // new flags
      logic                   sp_ld;  // load stack pointer
      logic [`IRQ_ADDR_W-1:0] sp;     // new stack pointer
   } core_load_t;

   // =====================================================
   // sources that ignore the mask flag
   function automatic logic nonmask(input int unsigned s);
      return (s == `IRQ_NMI_SRC) || (s == `IRQ_ABRK_SRC);
   endfunction

endpackage

// ### verilog/irq_seq_regs.svh
// constants for the interrupt acceptance sequencer
`ifndef IRQ_SEQ_REGS_SVH
`define IRQ_SEQ_REGS_SVH

// =====================================================
// widths
`define IRQ_ADDR_W   16
`define IRQ_FULL_W   24
`define IRQ_DATA_W   16
`define IRQ_CCR_W    8

// =====================================================
// condition code register layout
`define IRQ_CCR_IBIT 7

// =====================================================
// fixed source numbers
`define IRQ_NMI_SRC  0
`define IRQ_ABRK_SRC 1

// =====================================================
// stack stepping, one 16-bit word
`define IRQ_STK_STEP 24'h000002

// =====================================================
// reset values
`define IRQ_RST_ADDR 16'h0000
`define IRQ_RST_DATA 16'h0000
`define IRQ_RST_CCR  8'h00
`define IRQ_RST_FULL 24'h000000

`endif
